// ===== rtl/rcs_pkg.sv
// Constants for the runtime configuration and SMBus base register group
package rcs_pkg;
  // ****************************************
  // Register offsets (configuration index)
  // ****************************************
  localparam logic [7:0] RCS_OFS_SMB_HIGH = 8'h60;
  localparam logic [7:0] RCS_OFS_SMB_LOW = 8'h61;
  localparam logic [7:0] RCS_OFS_SLOW_CLK = 8'hf0;
  localparam logic [7:0] RCS_OFS_FLOPPY = 8'hf1;
  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] RCS_RST_SMB_HIGH = 8'h00;
  localparam logic [7:0] RCS_RST_SMB_LOW = 8'h00;
  localparam logic [7:0] RCS_RST_SLOW_CLK = 8'h00;
  localparam logic [7:0] RCS_RST_FLOPPY = 8'h00;
  // ****************************************
  // Field layouts
  // ****************************************
  localparam int RCS_BIT_CLK_ABSENT = 0;
  localparam int RCS_BIT_KEY_WAKE_DIS = 1;
  localparam logic [7:0] RCS_MASK_SLOW_CLK = 8'h03;
  localparam logic [7:0] RCS_MASK_FLOPPY = 8'h03;
  localparam logic [7:0] RCS_MASK_SMB_HIGH = 8'h0f;
  localparam logic [7:0] RCS_MASK_SMB_LOW = 8'hf8;
  localparam logic [15:0] RCS_SMB_BASE_MIN = 16'h0100;
  localparam logic [15:0] RCS_SMB_BASE_MAX = 16'h0ff8;
  // ****************************************
  // Floppy routing modes
  // ****************************************
  typedef enum logic [1:0] {
    RCS_ROUTE_BY_REG = 2'h0,
    RCS_ROUTE_PIN_D1 = 2'h1,
    RCS_ROUTE_PIN_BOTH = 2'h2,
    RCS_ROUTE_RSVD = 2'h3
  } rcs_route_type;
endpackage : rcs_pkg

// ===== rtl/rcs_reg8.sv
// One masked 8-bit configuration register
`timescale 1ns/10ps
module rcs_reg8 #(
  parameter logic [7:0] RESET_VALUE = 8'h00,
  parameter logic [7:0] WRITE_MASK = 8'hff
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic wr_en,
  input wire logic [7:0] wr_data,
  output logic [7:0] value
);
  logic [7:0] value_reg;
  logic [7:0] value_next;

  // Unwritable bits stay zero
  assign value_next = wr_en ? (wr_data & WRITE_MASK) : value_reg;
  assign value = value_reg;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      value_reg <= RESET_VALUE & WRITE_MASK;
    end else begin
      value_reg <= value_next;
    end
  end
endmodule : rcs_reg8

// ===== rtl/rcs_top.sv
// Runtime configuration and SMBus base register group, device side
// How it works
// R1 - Bit 0 of slow clock config: 0 means slow clock present, 1 absent.
// R2 - Bit 1 of slow clock config turns key wake logic off; default on.
// R3 - Key wake disabled blocks the slow clock to that logic.
// R4 - Floppy routing 00: printer port mode bits decide, select pin ignored.
// R5 - Routing 01 or 10: low select pin puts floppy on printer port pins.
// R6 - Routing 01 with pin active: drive 0 on floppy pins, drive 1 on port.
// R7 - Routing 10 with pin active: both drives on port pins; 11 reserved.
// R8 - SMBus base from A11..A8 high byte, A7..A3 low; range 0x0100-0x0ff8.
// R9 - Reserved and fixed-zero bits read zero; writes to them are ignored.
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/10ps
module rcs_top (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic slow_clock_pin,
  input wire logic floppy_routing_select,
  input wire logic pp_mode_floppy_on,
  input wire logic pp_mode_drive1_only,
  output logic key_wake_clock,
  output logic key_wake_enable,
  output logic slow_clock_absent,
  output logic floppy_on_printer_port,
  output logic drive0_on_printer_port,
  output logic drive1_on_printer_port,
  output logic [15:0] smbus_base,
  output logic smbus_base_valid
);
  import rcs_pkg::*;

  // ****************************************
  // Register bus decode
  // ****************************************
  logic sel_smb_high;
  logic sel_smb_low;
  logic sel_slow_clk;
  logic sel_floppy;
  logic [7:0] smb_high_val;
  logic [7:0] smb_low_val;
  logic [7:0] slow_clk_val;
  logic [7:0] floppy_val;
  logic [7:0] rdata_next;
  logic [7:0] rdata_reg;

  assign sel_smb_high = (reg_addr == RCS_OFS_SMB_HIGH);
  assign sel_smb_low = (reg_addr == RCS_OFS_SMB_LOW);
  assign sel_slow_clk = (reg_addr == RCS_OFS_SLOW_CLK);
  assign sel_floppy = (reg_addr == RCS_OFS_FLOPPY);

  // ****************************************
  // Registers
  // ****************************************
  // Write masks keep reserved and fixed bits at zero [R9]
  rcs_reg8 #(.RESET_VALUE(RCS_RST_SMB_HIGH), .WRITE_MASK(RCS_MASK_SMB_HIGH)) u_smb_high (
    .core_clk(core_clk),
    .rst(rst),
    .wr_en(reg_wr && sel_smb_high),
    .wr_data(reg_wdata),
    .value(smb_high_val)
  );
  rcs_reg8 #(.RESET_VALUE(RCS_RST_SMB_LOW), .WRITE_MASK(RCS_MASK_SMB_LOW)) u_smb_low (
    .core_clk(core_clk),
    .rst(rst),
    .wr_en(reg_wr && sel_smb_low),
    .wr_data(reg_wdata),
    .value(smb_low_val)
  );
  rcs_reg8 #(.RESET_VALUE(RCS_RST_SLOW_CLK), .WRITE_MASK(RCS_MASK_SLOW_CLK)) u_slow_clk (
    .core_clk(core_clk),
    .rst(rst),
    .wr_en(reg_wr && sel_slow_clk),
    .wr_data(reg_wdata),
    .value(slow_clk_val)
  );
  rcs_reg8 #(.RESET_VALUE(RCS_RST_FLOPPY), .WRITE_MASK(RCS_MASK_FLOPPY)) u_floppy (
    .core_clk(core_clk),
    .rst(rst),
    .wr_en(reg_wr && sel_floppy),
    .wr_data(reg_wdata),
    .value(floppy_val)
  );

  // Unmapped index reads zero [R9]
  assign rdata_next = sel_smb_high ? smb_high_val :
                      sel_smb_low ? smb_low_val :
                      sel_slow_clk ? slow_clk_val :
                      sel_floppy ? floppy_val : 8'h00;

  // ****************************************
  // Slow clock and key wake
  // ****************************************
  logic absent_next;
  logic wake_en_next;
  logic wake_clk_next;
  logic absent_reg;
  logic wake_en_reg;
  logic wake_clk_reg;

  assign absent_next = slow_clk_val[RCS_BIT_CLK_ABSENT]; // [R1]
  assign wake_en_next = ~slow_clk_val[RCS_BIT_KEY_WAKE_DIS]; // [R2]
  // Gate off the slow clock when logic is off or clock absent [R3]
  assign wake_clk_next = slow_clock_pin & wake_en_next & ~absent_next; // [R3]

  // ****************************************
  // Floppy routing
  // ****************************************
  rcs_route_type route_mode;
  logic pin_active;
  logic fop_next;
  logic d0_next;
  logic d1_next;
  logic fop_reg;
  logic d0_reg;
  logic d1_reg;

  assign route_mode = rcs_route_type'(floppy_val[1:0]);
  // Select pin is active low: low means floppy on the port [R5]
  assign pin_active = ~floppy_routing_select;

  always_comb begin
    fop_next = 1'b0;
    d0_next = 1'b0;
    d1_next = 1'b0;
    unique case (route_mode)
      RCS_ROUTE_BY_REG: begin
        // Printer port mode bits decide, pin ignored [R4]
        fop_next = pp_mode_floppy_on;
        d0_next = pp_mode_floppy_on & ~pp_mode_drive1_only;
        d1_next = pp_mode_floppy_on;
      end
      RCS_ROUTE_PIN_D1: begin
        fop_next = pin_active; // [R5]
        d0_next = 1'b0; // [R6]
        d1_next = pin_active; // [R6]
      end
      RCS_ROUTE_PIN_BOTH: begin
        fop_next = pin_active; // [R5]
        d0_next = pin_active; // [R7]
        d1_next = pin_active; // [R7]
      end
      RCS_ROUTE_RSVD: begin
        // Reserved mode leaves the port with the printer [R7]
        fop_next = 1'b0;
      end
    endcase
  end

  // ****************************************
  // SMBus base
  // ****************************************
  logic [15:0] base_next;
  logic base_valid_next;
  logic [15:0] base_reg;
  logic base_valid_reg;

  // A11..A8 from high byte, A7..A3 from low byte [R8]
  assign base_next = {4'h0, smb_high_val[3:0], smb_low_val[7:3], 3'h0}; // [R8]
  assign base_valid_next = (base_next >= RCS_SMB_BASE_MIN) &&
                           (base_next <= RCS_SMB_BASE_MAX); // [R8]

  // ****************************************
  // Output flops
  // ****************************************
  // Read data stands in the cycle after each reg_rd cycle, zero otherwise
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= reg_rd ? rdata_next : 8'h00;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      absent_reg <= 1'b0;
    end else begin
      absent_reg <= absent_next;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      wake_en_reg <= 1'b0;
    end else begin
      wake_en_reg <= wake_en_next;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      wake_clk_reg <= 1'b0;
    end else begin
      wake_clk_reg <= wake_clk_next;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      fop_reg <= 1'b0;
    end else begin
      fop_reg <= fop_next;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      d0_reg <= 1'b0;
    end else begin
      d0_reg <= d0_next;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      d1_reg <= 1'b0;
    end else begin
      d1_reg <= d1_next;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      base_reg <= 16'h0000;
    end else begin
      base_reg <= base_next;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      base_valid_reg <= 1'b0;
    end else begin
      base_valid_reg <= base_valid_next;
    end
  end

  assign reg_rdata = rdata_reg;
  assign slow_clock_absent = absent_reg;
  assign key_wake_enable = wake_en_reg;
  assign key_wake_clock = wake_clk_reg;
  assign floppy_on_printer_port = fop_reg;
  assign drive0_on_printer_port = d0_reg;
  assign drive1_on_printer_port = d1_reg;
  assign smbus_base = base_reg;
  assign smbus_base_valid = base_valid_reg;
endmodule : rcs_top

// ===== verif/rcs_top_assertions.sv
// Port checker for the register group
`timescale 1ns/10ps
module rcs_top_chk (
  input wire logic core_clk, rst, reg_wr, reg_rd, slow_clock_pin, smbus_base_valid,
  input wire logic key_wake_clock, key_wake_enable, slow_clock_absent,
  input wire logic floppy_on_printer_port, drive0_on_printer_port, drive1_on_printer_port,
  input wire logic [7:0] reg_addr, reg_wdata, reg_rdata,
  input wire logic [15:0] smbus_base
);
  import rcs_pkg::*;
  wire wr_ck = reg_wr && reg_addr == RCS_OFS_SLOW_CLK;
  wire kw_on = key_wake_enable && !slow_clock_absent;
  wire in_rng = smbus_base >= 16'h0100 && smbus_base <= 16'h0ff8;
  wire unmap = reg_addr[7:1] != 7'h30 && reg_addr[7:1] != 7'h78;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  property p_gate; key_wake_clock == ($past(slow_clock_pin) && kw_on); endproperty
  a_gate: assert property (p_gate) else $error("wake clock");
  property p_wake; wr_ck |-> ##2 key_wake_enable == !$past(reg_wdata[1], 2); endproperty
  a_wake: assert property (p_wake) else $error("wake enable");
  property p_abs; wr_ck |-> ##2 slow_clock_absent == $past(reg_wdata[0], 2); endproperty
  a_abs: assert property (p_abs) else $error("clock absent");
  property p_fix; smbus_base[15:12] == 4'h0 && smbus_base[2:0] == 3'h0; endproperty
  a_fix: assert property (p_fix) else $error("base bits");
  property p_rng; smbus_base_valid == in_rng; endproperty
  a_rng: assert property (p_rng) else $error("base range");
  property p_d1; drive1_on_printer_port == floppy_on_printer_port; endproperty
  a_d1: assert property (p_d1) else $error("drive 1");
  property p_d0; drive0_on_printer_port |-> floppy_on_printer_port; endproperty
  a_d0: assert property (p_d0) else $error("drive 0");
  property p_unmap; reg_rd && unmap |=> reg_rdata == 8'h00; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read");
endmodule : rcs_top_chk
bind rcs_top rcs_top_chk u_chk (.*);

// ===== verif/rcs_top_tb_top.sv
// Random and corner bench for the register group
`timescale 1ns/10ps
module rcs_top_tb_top;
  import rcs_pkg::*;
  logic core_clk, rst, reg_wr, reg_rd, slow_clock_pin, floppy_routing_select;
  logic pp_mode_floppy_on, pp_mode_drive1_only, key_wake_clock, key_wake_enable;
  logic slow_clock_absent, floppy_on_printer_port, drive0_on_printer_port;
  logic drive1_on_printer_port, smbus_base_valid;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, hi, lo, ck, fl;
  logic [15:0] smbus_base, eb;
  logic [31:0] r;
  logic [31:0] seed = 32'hc860;
  int err_count = 0;
  int n_tests = 0;
  rcs_top u_dut (.*);
  function automatic logic [31:0] nxt();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : nxt
  // Floppy, drive 0, drive 1
  function automatic logic [2:0] exp_fl(logic [1:0] m, logic s, logic on, logic o1);
    if (m == 2'h0) return {on, on & ~o1, on};
    if (m == 2'h3 || s) return 3'h0;
    return m[1] ? 3'h7 : 3'h5;
  endfunction : exp_fl
  task automatic chk(logic [15:0] seen, logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %0t saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // Write, or read and compare
  task automatic acc(logic w, logic [7:0] a, logic [7:0] d);
    @(posedge core_clk);
    {reg_addr, reg_wdata, reg_wr, reg_rd} <= {a, d, w, !w};
    @(posedge core_clk);
    {reg_wr, reg_rd} <= 2'h0;
    if (!w) #1 chk(reg_rdata, d);
  endtask : acc
  task automatic final_report();
    $display("%0d checks, %0d errors", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : final_report
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  initial begin
    repeat (6000) @(posedge core_clk);
    err_count++;
    final_report();
  end
  initial begin
    {reg_addr, reg_wdata, reg_wr, reg_rd, rst} = 19'h1;
    {slow_clock_pin, floppy_routing_select, pp_mode_floppy_on, pp_mode_drive1_only} = 4'h0;
    for (int k = 0; k < 2; k++) begin
      @(posedge core_clk);
      rst <= 1'b1;
      repeat (10) @(posedge core_clk);
      rst <= 1'b0;
      repeat (2) @(posedge core_clk);
      #1 chk(key_wake_enable, 1'b1);
      acc(1'b0, RCS_OFS_SLOW_CLK, 8'h00);
      for (int i = 0; i < (k ? 4 : 48); i++) begin
        r = nxt();
        hi = (i == 0) ? 8'h0f : (i < 3) ? {7'h0, i[0]} : r[7:0];
        lo = (i == 0) ? 8'hff : (i == 1) ? 8'h07 : (i == 2) ? 8'hf8 : r[15:8];
        ck = r[23:16];
        fl = {r[31:26], i[1:0]};
        acc(1'b1, RCS_OFS_SMB_HIGH, hi);
        acc(1'b1, RCS_OFS_SMB_LOW, lo);
        acc(1'b1, RCS_OFS_SLOW_CLK, ck);
        acc(1'b1, RCS_OFS_FLOPPY, fl);
        acc(1'b1, {r[31:26], 2'h2}, r[15:8]);
        {slow_clock_pin, floppy_routing_select} <= r[11:10];
        {pp_mode_floppy_on, pp_mode_drive1_only} <= r[9:8];
        repeat (2) @(posedge core_clk);
        eb = {4'h0, hi[3:0], lo[7:3], 3'h0};
        #1 chk(smbus_base, eb);
        chk(smbus_base_valid, eb >= 16'h0100 && eb <= 16'h0ff8);
        chk(slow_clock_absent, ck[0]);
        chk(key_wake_enable, !ck[1]);
        chk(key_wake_clock, r[11] && ck[1:0] == 2'h0);
        chk({floppy_on_printer_port, drive0_on_printer_port, drive1_on_printer_port},
            exp_fl(fl[1:0], r[10], r[9], r[8]));
        acc(1'b0, RCS_OFS_SMB_HIGH, {4'h0, hi[3:0]});
        acc(1'b0, RCS_OFS_SMB_LOW, {lo[7:3], 3'h0});
        acc(1'b0, RCS_OFS_SLOW_CLK, {6'h0, ck[1:0]});
        acc(1'b0, RCS_OFS_FLOPPY, {6'h0, fl[1:0]});
        acc(1'b0, {r[31:26], 2'h2}, 8'h00);
      end
    end
    final_report();
  end
endmodule : rcs_top_tb_top
